// ==== src/sbg_defines.svh ====
`ifndef SBG_DEFINES_SVH
`define SBG_DEFINES_SVH
// ****************************************
// Register indices, byte address = 4 x index
// ****************************************
`define SBG_IX_ZERO_SPEED_STATUS 10'h14C
`define SBG_IX_OFFDLY 10'h156
`define SBG_IX_NUM0 10'h158
`define SBG_IX_DEN 10'h15A
`define SBG_IX_PPR 10'h15C
`define SBG_IX_SPR 10'h15E
`define SBG_IX_MCSEL 10'h160
`define SBG_IX_OHMS 10'h168
`define SBG_IX_WATTS 10'h16A
`define SBG_IX_PWID 10'h16C
`define SBG_IX_MAXSPD 10'h198
`define SBG_IX_NUMX 10'h1C0
`define SBG_IX_CDLY 10'h1C6
`define SBG_IX_DOSEL 10'h1C8
`define SBG_IX_CTRL 10'h1CA
`define SBG_IX_STAT 10'h1CC
// ****************************************
// Reset values and legal ranges
// ****************************************
`define SBG_RST_ZERO_SPEED_STATUS 32'h0000_0064
`define SBG_RST_NUM 32'h0000_0080
`define SBG_RST_DEN 32'h0000_000A
`define SBG_RST_PPR 32'h0000_09C4
`define SBG_RST_SPR 32'h0000_000A
`define SBG_RST_OHMS 32'h0000_02EF
`define SBG_RST_WATTS 32'h0000_0BB9
`define SBG_RST_PWID 32'h0000_3200
`define SBG_RST_MAXSPD 32'h0000_1771
`define SBG_RST_DOSEL 32'h0000_0017
`define SBG_NUM_MAX 32'h1FFF_FFFF
`define SBG_DEN_MAX 32'h7FFF_FFFF
`define SBG_PPR_MIN 32'h0000_0014
`define SBG_PPR_MAX 32'h0004_E200
`define SBG_SPR_MAX 32'h0000_012C
`define SBG_ZERO_SPEED_STATUS_MAX 32'h0000_07D0
`define SBG_DLY_LIM 32'h0000_03E8
`define SBG_PWID_MAX 32'h0013_8800
`define SBG_OHMS_MIN 32'h0000_000A
`define SBG_WATTS_MIN 32'h0000_001E
`define SBG_MAXSPD_MIN 32'h0000_000A
`define SBG_MCSEL_BAD 32'hFFFF_FFEE
`define SBG_MC_LATCH_BIT 4
`define SBG_MC_ALM_BIT 0
`define SBG_DO_MC 8'h17
`define SBG_SPD_SCALE 32'h0000_000A
`define SBG_AL018_LIM 36'h0_B106_9A80
`define SBG_ENC_CPR 32'h0013_8800
`define SBG_GEAR_DW 48
// ****************************************
// Control and status bits
// ****************************************
`define SBG_CTRL_SON 0
`define SBG_CTRL_MODE 1
`define SBG_ST_AL018 0
`define SBG_ST_AL380 1
// ****************************************
// Timing
// ****************************************
`define SBG_CLK_HZ 32'h017D_7840
`define SBG_DLY_UNIT_MS 32'h0000_0001
`endif

// ==== src/sbg_pkg.sv ====
package sbg_pkg;
	// Holding brake sequencing states
	typedef enum logic [1:0] {
		BRK_ON,
		BRK_PRE,
		BRK_WAIT,
		BRK_OFF
	} sbg_brk_t;
endpackage

// ==== src/sbg_status.sv ====
// Overview of operation
// R1 - Below zero speed, brake engages before delay
// R2 - Delay expired, brake engages regardless of speed
// R3 - Forced stop treats negative delay as zero
// R4 - First numerator 32-bit, 1..536870911, default 128
// R5 - Pulse-train mode: numerator writable only enabled
// R6 - Internal mode: numerator writable only disabled
// R7 - Denominator 1..2147483647, locked while enabled
// R8 - Software keeps gear ratio within bounds
// R9 - Position step = pulses*N/M with remainder
// R10 - Encoder output pulses per rev 20..320000
// R11 - Encoder output alarm on fault or overspeed
// R12 - Speed reached when speed error within range
// R13 - Speed error uses raw user command
// R14 - Range zero keeps speed reached off
// R15 - Motion complete selectable, select 0..0x0011
// R16 - New command clears done, reached, complete
// R17 - Command done after profile end plus delay
// R18 - Position reached when error within width
// R19 - Latch off: complete equals done and reached
// R20 - Latch on: complete stays set
// R21 - Alarm enable: deviation alarm after complete
// R22 - Zero speed when speed within range
// R23 - Brake release drops after off delay
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "sbg_defines.svh"
module sbg_status #(
	parameter int unsigned MS_CYC = `SBG_CLK_HZ / 1000 * `SBG_DLY_UNIT_MS,
	parameter int unsigned ENC_CPR = `SBG_ENC_CPR,
	parameter int unsigned NUM_CNT = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire logic i_op_stop,
	input wire logic i_alarm,
	input wire logic i_alarm_is_022,
	input wire logic signed [16:0] i_motor_speed,
	input wire logic signed [15:0] i_spd_cmd_raw,
	input wire logic signed [15:0] i_spd_fb_filt,
	input wire logic i_enc_fault,
	input wire logic i_enc_count,
	input wire logic i_enc_dir,
	input wire logic i_pulse_in,
	input wire logic i_pulse_dir,
	input wire logic [1:0] i_num_sel,
	input wire logic i_prof_start,
	input wire logic i_prof_end,
	input wire logic [31:0] i_pos_err,
	output logic o_brake_release,
	output logic o_drive_en,
	output logic o_zero_speed,
	output logic o_speed_reached,
	output logic o_cmd_done,
	output logic o_pos_reached,
	output logic o_motion_complete,
	output logic o_do_mc,
	output logic o_alarm_018,
	output logic o_alarm_380,
	output logic o_enc_pulse,
	output logic o_enc_dir,
	output logic signed [31:0] o_pos_delta,
	output logic o_pos_valid
);
	// ****************************************
	// Parameter checks
	// ****************************************
	if (ENC_CPR < `SBG_PPR_MAX || ENC_CPR >= 32'h0020_0000 || NUM_CNT < 1 || NUM_CNT > 4
			|| MS_CYC < 1 || MS_CYC >= 32'h0001_0000) begin : g_bad
		$error("sbg_status: parameter out of range");
	end

	localparam int GW = `SBG_GEAR_DW;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] operational_stop_sy_q, pul_sy_q, pdir_sy_q;
	logic pul_old_q;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			operational_stop_sy_q <= '0;
			pul_sy_q <= '0;
			pdir_sy_q <= '0;
			pul_old_q <= 1'b0;
		end else begin
			operational_stop_sy_q <= {operational_stop_sy_q[0], i_op_stop};
			pul_sy_q <= {pul_sy_q[0], i_pulse_in};
			pdir_sy_q <= {pdir_sy_q[0], i_pulse_dir};
			pul_old_q <= pul_sy_q[1];
		end
	end
	wire operational_stop = operational_stop_sy_q[1];
	wire pul_edge = pul_sy_q[1] & ~pul_old_q;

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	logic [31:0] zero_speed_status_q, offdly_q, den_q, ppr_q, spr_q, mcsel_q;
	logic [31:0] ohms_q, watts_q, pwid_q, maxspd_q, cdly_q, dosel_q, ctrl_q;
	logic [31:0] num_q [4];
	logic wr_q;
	logic [9:0] wix_q;
	logic [31:0] rd_d;
	logic [8:0] stat;
	wire ap = i_hsel & i_hready & i_htrans[1];
	wire [9:0] aix = (i_haddr[31:12] == '0) ? i_haddr[11:2] : 10'h3FF;
	wire [31:0] wv = i_hwdata;
	wire son = ctrl_q[`SBG_CTRL_SON];
	wire mode_int = ctrl_q[`SBG_CTRL_MODE];

	// Address phase capture, zero wait states
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_q <= 1'b0;
			wix_q <= '0;
			o_hrdata <= '0;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end else begin
			wr_q <= ap & i_hwrite;
			wix_q <= aix;
			if (ap && !i_hwrite) begin
				o_hrdata <= rd_d;
			end
		end
	end

	function automatic logic in_rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	function automatic logic [9:0] num_ix(input int i);
		return (i == 0) ? `SBG_IX_NUM0 : 10'(`SBG_IX_NUMX + 10'(2 * (i - 1)));
	endfunction

	// Numerator writes gated by mode and drive state
	wire num_ok = mode_int ? ~o_drive_en : o_drive_en; // see R5 see R6
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < 4; i++) begin
				num_q[i] <= `SBG_RST_NUM;
			end
		end else begin
			for (int i = 0; i < NUM_CNT; i++) begin
				if (wr_q && wix_q == num_ix(i) && num_ok && in_rng(wv, 32'h0000_0001, `SBG_NUM_MAX)) begin
					num_q[i] <= wv; // see R4
				end
			end
		end
	end

	// Configuration writes, out-of-range values ignored, except DOSEL and CTRL, which keep only their low bits
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			zero_speed_status_q <= `SBG_RST_ZERO_SPEED_STATUS;
			offdly_q <= '0;
			den_q <= `SBG_RST_DEN;
			ppr_q <= `SBG_RST_PPR;
			spr_q <= `SBG_RST_SPR;
			mcsel_q <= '0;
			ohms_q <= `SBG_RST_OHMS;
			watts_q <= `SBG_RST_WATTS;
			pwid_q <= `SBG_RST_PWID;
			maxspd_q <= `SBG_RST_MAXSPD;
			cdly_q <= '0;
			dosel_q <= `SBG_RST_DOSEL;
			ctrl_q <= '0;
		end else if (wr_q) begin
			unique case (wix_q)
				`SBG_IX_ZERO_SPEED_STATUS: if (wv <= `SBG_ZERO_SPEED_STATUS_MAX) zero_speed_status_q <= wv;
				`SBG_IX_OFFDLY: if ($signed(wv) >= -$signed(`SBG_DLY_LIM) && $signed(wv) <= $signed(`SBG_DLY_LIM)) offdly_q <= wv;
				`SBG_IX_DEN: if (!o_drive_en && in_rng(wv, 32'h0000_0001, `SBG_DEN_MAX)) den_q <= wv; // see R7
				`SBG_IX_PPR: if (in_rng(wv, `SBG_PPR_MIN, `SBG_PPR_MAX)) ppr_q <= wv; // see R10
				`SBG_IX_SPR: if (wv <= `SBG_SPR_MAX) spr_q <= wv;
				`SBG_IX_MCSEL: if ((wv & `SBG_MCSEL_BAD) == '0) mcsel_q <= wv; // see R15
				`SBG_IX_OHMS: if (in_rng(wv, `SBG_OHMS_MIN, `SBG_RST_OHMS)) ohms_q <= wv;
				`SBG_IX_WATTS: if (in_rng(wv, `SBG_WATTS_MIN, `SBG_RST_WATTS)) watts_q <= wv;
				`SBG_IX_PWID: if (wv <= `SBG_PWID_MAX) pwid_q <= wv;
				`SBG_IX_MAXSPD: if (in_rng(wv, `SBG_MAXSPD_MIN, `SBG_RST_MAXSPD)) maxspd_q <= wv;
				`SBG_IX_CDLY: if (wv <= `SBG_DLY_LIM) cdly_q <= wv;
				`SBG_IX_DOSEL: dosel_q <= {24'h00_0000, wv[7:0]};
				`SBG_IX_CTRL: ctrl_q <= {30'h0000_0000, wv[1:0]};
				default: ;
			endcase
		end
	end

	// Read multiplexer, unmapped reads zero
	always_comb begin
		rd_d = '0;
		unique case (aix)
			`SBG_IX_ZERO_SPEED_STATUS: rd_d = zero_speed_status_q;
			`SBG_IX_OFFDLY: rd_d = offdly_q;
			`SBG_IX_DEN: rd_d = den_q;
			`SBG_IX_PPR: rd_d = ppr_q;
			`SBG_IX_SPR: rd_d = spr_q;
			`SBG_IX_MCSEL: rd_d = mcsel_q;
			`SBG_IX_OHMS: rd_d = ohms_q;
			`SBG_IX_WATTS: rd_d = watts_q;
			`SBG_IX_PWID: rd_d = pwid_q;
			`SBG_IX_MAXSPD: rd_d = maxspd_q;
			`SBG_IX_CDLY: rd_d = cdly_q;
			`SBG_IX_DOSEL: rd_d = dosel_q;
			`SBG_IX_CTRL: rd_d = ctrl_q;
			`SBG_IX_STAT: rd_d = {23'h00_0000, stat};
			default: ;
		endcase
		for (int i = 0; i < NUM_CNT; i++) begin
			if (aix == num_ix(i)) rd_d = num_q[i];
		end
	end
	assign stat = {o_drive_en, o_brake_release, o_motion_complete, o_pos_reached, o_cmd_done,
		o_speed_reached, o_zero_speed, o_alarm_380, o_alarm_018};
	wire clr018 = wr_q && wix_q == `SBG_IX_STAT && wv[`SBG_ST_AL018];
	wire clr380 = wr_q && wix_q == `SBG_IX_STAT && wv[`SBG_ST_AL380];

	// ****************************************
	// Millisecond ticks
	// ****************************************
	logic [15:0] bdiv_q, fdiv_q;
	logic [10:0] bcnt_q, ccnt_q;
	sbg_pkg::sbg_brk_t brk_q, brk_d;
	wire ftick = fdiv_q == 16'(MS_CYC - 1);
	wire btick = bdiv_q == 16'(MS_CYC - 1);
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			fdiv_q <= '0;
			bdiv_q <= '0;
			bcnt_q <= '0;
		end else begin
			fdiv_q <= ftick ? '0 : fdiv_q + 16'h0001;
			if (brk_d != brk_q) begin
				bdiv_q <= '0;
				bcnt_q <= '0;
			end else begin
				bdiv_q <= btick ? '0 : bdiv_q + 16'h0001;
				if (btick) bcnt_q <= bcnt_q + 11'h001;
			end
		end
	end

	// ****************************************
	// Holding brake sequencing
	// ****************************************
	wire forced = (i_alarm & ~i_alarm_is_022) | operational_stop;
	wire off_req = ~son | i_alarm | operational_stop;
	wire dly_neg = offdly_q[31];
	wire [10:0] dly_abs = dly_neg ? 11'(-offdly_q) : offdly_q[10:0];

	always_comb begin
		brk_d = brk_q;
		unique case (brk_q)
			sbg_pkg::BRK_ON: if (off_req) begin
				if (dly_neg && !forced) brk_d = sbg_pkg::BRK_PRE;
				else if (dly_neg || dly_abs == '0) brk_d = sbg_pkg::BRK_OFF; // see R3
				else brk_d = sbg_pkg::BRK_WAIT;
			end
			sbg_pkg::BRK_PRE: begin
				if (!off_req) brk_d = sbg_pkg::BRK_ON;
				else if (forced || bcnt_q == dly_abs) brk_d = sbg_pkg::BRK_OFF; // see R3
			end
			sbg_pkg::BRK_WAIT: begin
				if (!off_req) brk_d = sbg_pkg::BRK_ON;
				else if (o_zero_speed) brk_d = sbg_pkg::BRK_OFF; // see R1
				else if (bcnt_q == dly_abs) brk_d = sbg_pkg::BRK_OFF; // see R2 see R23
			end
			sbg_pkg::BRK_OFF: if (!off_req) brk_d = sbg_pkg::BRK_ON;
		endcase
	end

	// Brake and drive outputs follow the next state
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			brk_q <= sbg_pkg::BRK_OFF;
			o_brake_release <= 1'b0;
			o_drive_en <= 1'b0;
		end else begin
			brk_q <= brk_d;
			o_brake_release <= brk_d == sbg_pkg::BRK_ON || brk_d == sbg_pkg::BRK_WAIT; // see R23
			o_drive_en <= brk_d == sbg_pkg::BRK_ON || brk_d == sbg_pkg::BRK_PRE;
		end
	end

	// ****************************************
	// Speed status and encoder output
	// ****************************************
	wire [16:0] spd_abs = i_motor_speed[16] ? 17'(-i_motor_speed) : 17'(i_motor_speed);
	wire signed [16:0] serr = {i_spd_cmd_raw[15], i_spd_cmd_raw} - {i_spd_fb_filt[15], i_spd_fb_filt}; // see R13
	wire [16:0] serr_abs = serr[16] ? 17'(-serr) : 17'(serr);
	wire [35:0] fprod = 36'(spd_abs) * 36'(ppr_q[18:0]);
	wire over = i_enc_fault || {15'h0000, spd_abs} > 32'(maxspd_q * `SBG_SPD_SCALE)
		|| fprod > `SBG_AL018_LIM;
	logic [20:0] acc_q;
	wire [21:0] acc_sum = {1'b0, acc_q} + 22'(ppr_q[18:0]);

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_zero_speed <= 1'b0;
			o_speed_reached <= 1'b0;
			o_alarm_018 <= 1'b0;
		end else begin
			o_zero_speed <= {15'h0000, spd_abs} <= zero_speed_status_q; // see R22
			o_speed_reached <= spr_q != '0 && {15'h0000, serr_abs} <= spr_q; // see R12 see R14
			o_alarm_018 <= over | (o_alarm_018 & ~clr018); // see R11
		end
	end

	// Rate multiplier from encoder counts to output pulses
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_q <= '0;
			o_enc_pulse <= 1'b0;
			o_enc_dir <= 1'b0;
		end else begin
			o_enc_pulse <= 1'b0;
			if (i_enc_count) begin
				o_enc_dir <= i_enc_dir;
				if (acc_sum >= 22'(ENC_CPR)) begin
					acc_q <= 21'(acc_sum - 22'(ENC_CPR)); // see R10
					o_enc_pulse <= 1'b1;
				end else begin
					acc_q <= acc_sum[20:0];
				end
			end
		end
	end

	// ****************************************
	// Electronic gear divider
	// ****************************************
	logic signed [15:0] pend_q;
	logic signed [31:0] rem_q;
	logic gbusy_q, gneg_q;
	logic [5:0] gcnt_q;
	logic [GW-1:0] gdvd_q, gquo_q;
	logic [31:0] grem_q;
	wire signed [15:0] pinc = !pul_edge ? 16'sh0000 : (pdir_sy_q[1] ? -16'sh0001 : 16'sh0001);
	wire gstart = !gbusy_q && pend_q != '0;
	wire signed [GW-1:0] gx = GW'(rem_q) + GW'(pend_q) * $signed({16'h0000, num_q[i_num_sel]});
	wire [32:0] gtry = {grem_q, gdvd_q[GW-1]} - {1'b0, den_q};
	wire gtake = ~gtry[32];
	wire [31:0] g_nr = gtake ? gtry[31:0] : {grem_q[30:0], gdvd_q[GW-1]};
	wire [GW-1:0] g_nq = {gquo_q[GW-2:0], gtake};

	// Restoring division, remainder carried to next batch
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_q <= '0;
			rem_q <= '0;
			gbusy_q <= 1'b0;
			gneg_q <= 1'b0;
			gcnt_q <= '0;
			gdvd_q <= '0;
			gquo_q <= '0;
			grem_q <= '0;
			o_pos_delta <= '0;
			o_pos_valid <= 1'b0;
		end else begin
			o_pos_valid <= 1'b0;
			pend_q <= (gstart ? 16'sh0000 : pend_q) + pinc;
			if (gstart) begin
				gbusy_q <= 1'b1;
				gneg_q <= gx[GW-1];
				gdvd_q <= gx[GW-1] ? GW'(-gx) : GW'(gx);
				gquo_q <= '0;
				grem_q <= '0;
				gcnt_q <= '0;
			end else if (gbusy_q) begin
				gdvd_q <= {gdvd_q[GW-2:0], 1'b0};
				gquo_q <= g_nq;
				grem_q <= g_nr;
				gcnt_q <= gcnt_q + 6'h01;
				if (gcnt_q == 6'(GW - 1)) begin
					gbusy_q <= 1'b0;
					o_pos_valid <= 1'b1;
					o_pos_delta <= gneg_q ? -$signed(32'(g_nq)) : $signed(32'(g_nq)); // see R9
					rem_q <= gneg_q ? -$signed(g_nr) : $signed(g_nr); // see R9
				end
			end
		end
	end

	// ****************************************
	// Command done and motion complete
	// ****************************************
	logic cd_run_q, armed_q;
	wire mc_latch = mcsel_q[`SBG_MC_LATCH_BIT];
	wire mc_alm = mcsel_q[`SBG_MC_ALM_BIT];
	wire both = o_cmd_done & o_pos_reached;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cd_run_q <= 1'b0;
			ccnt_q <= '0;
			o_cmd_done <= 1'b0;
			o_pos_reached <= 1'b0;
			o_motion_complete <= 1'b0;
			armed_q <= 1'b0;
		end else if (i_prof_start) begin
			cd_run_q <= 1'b0;
			o_cmd_done <= 1'b0; // see R16
			o_pos_reached <= 1'b0;
			o_motion_complete <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			o_pos_reached <= i_pos_err <= pwid_q; // see R18
			if (i_prof_end) begin
				cd_run_q <= 1'b1;
				ccnt_q <= '0;
			end else if (cd_run_q) begin
				if ({21'h00_0000, ccnt_q} >= cdly_q) begin
					o_cmd_done <= 1'b1; // see R17
					cd_run_q <= 1'b0;
				end else if (ftick) begin
					ccnt_q <= ccnt_q + 11'h001;
				end
			end
			o_motion_complete <= mc_latch ? (o_motion_complete | both) : both; // see R19 see R20
			armed_q <= armed_q | o_motion_complete;
		end
	end

	// Deviation alarm and selectable output
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_alarm_380 <= 1'b0;
			o_do_mc <= 1'b0;
		end else begin
			o_alarm_380 <= (mc_alm & armed_q & ~i_prof_start & (~o_pos_reached | ~o_motion_complete))
				| (o_alarm_380 & ~clr380); // see R21
			o_do_mc <= dosel_q[7:0] == `SBG_DO_MC && o_motion_complete; // see R15
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence s_num_wr;
		wr_q && wix_q == `SBG_IX_NUM0;
	endsequence
	sequence s_both_on;
		o_cmd_done && o_pos_reached && !i_prof_start;
	endsequence

	a_brk_zero_speed: assert property ((brk_q == sbg_pkg::BRK_WAIT && off_req && o_zero_speed) |=> !o_brake_release) // see R1
		else $error("brake not engaged at zero speed");
	a_brk_delay_end: assert property ((brk_q == sbg_pkg::BRK_WAIT && off_req && bcnt_q == dly_abs) |=> !o_brake_release) // see R2
		else $error("brake not engaged after delay");
	a_brk_forced_neg: assert property ((brk_q == sbg_pkg::BRK_ON && off_req && forced && dly_neg)
		|=> (!o_drive_en && !o_brake_release)) // see R3
		else $error("negative delay not zero on forced stop");
	a_num_pt_lock: assert property ((s_num_wr and (!mode_int && !o_drive_en)) |=> $stable(num_q[0])) // see R5
		else $error("numerator changed while disabled");
	a_num_pr_lock: assert property ((s_num_wr and (mode_int && o_drive_en)) |=> $stable(num_q[0])) // see R6
		else $error("numerator changed while enabled");
	a_den_lock: assert property ((wr_q && wix_q == `SBG_IX_DEN && o_drive_en) |=> $stable(den_q)) // see R7
		else $error("denominator changed while enabled");
	a_spd_zero_off: assert property ((spr_q == '0) [*2] |-> !o_speed_reached) // see R14
		else $error("speed reached with zero range");
	a_al018_fault: assert property (i_enc_fault |=> o_alarm_018 [*2] or (o_alarm_018 ##1 clr018)) // see R11
		else $error("encoder fault missed");
	a_new_cmd_clear: assert property (i_prof_start |=> (!o_cmd_done && !o_pos_reached && !o_motion_complete)) // see R16
		else $error("new command did not clear status");
	a_mc_follow: assert property ((!mc_latch && !i_prof_start) |=> o_motion_complete == $past(both)) // see R19
		else $error("motion complete not and of inputs");
	a_mc_hold: assert property (s_both_on ##1 (mc_latch && !i_prof_start) |=> o_motion_complete) // see R20
		else $error("latched motion complete dropped");
	a_al380_set: assert property ((mc_alm && armed_q && !o_pos_reached && !i_prof_start) |=> o_alarm_380) // see R21
		else $error("deviation alarm missed");
	a_enc_ratio: assert property (o_enc_pulse |-> $past(i_enc_count)) // see R10
		else $error("encoder pulse without count");
endmodule // sbg_status
`default_nettype wire

// ==== tb/sbg_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sbg_far_model (
	input wire logic i_ref_clk,
	output logic o_prof_start,
	output logic o_prof_end,
	output logic o_enc_count
);
	// Strobes idle low
	initial begin
		o_prof_start = 1'b0;
		o_prof_end = 1'b0;
		o_enc_count = 1'b0;
	end
	// One-cycle strobe: 0 start, 1 end, above 1 encoder count
	task automatic strobe(input int k);
		@(posedge i_ref_clk);
		o_prof_start <= (k == 0);
		o_prof_end <= (k == 1);
		o_enc_count <= (k > 1);
		@(posedge i_ref_clk);
		o_prof_start <= 1'b0;
		o_prof_end <= 1'b0;
		o_enc_count <= 1'b0;
	endtask
endmodule // sbg_far_model
`default_nettype wire

// ==== tb/servo_brake_gear_status_logic_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sbg_defines.svh"
module servo_brake_gear_status_logic_test;
	logic clk, rst, hsel, hwrite, hro, hresp, alarm, enc_fault, enc_dir, ps, pe, ec;
	logic brk, den, zs, speed_reached_range, done, posr, mc, domc, a18, a380, encp, encd, pv;
	logic ops, a22, pin, pdir;
	logic [1:0] nsel;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, pos_err, rd;
	logic signed [16:0] speed;
	logic signed [15:0] cmd, fb;
	logic signed [31:0] pdelta;
	int failures, checks, cycles, npulse;
	localparam logic [9:0] RIX [8] = '{`SBG_IX_NUM0, `SBG_IX_DEN, `SBG_IX_PPR, `SBG_IX_SPR,
		`SBG_IX_MCSEL, `SBG_IX_OHMS, `SBG_IX_WATTS, 10'h3FF};
	localparam logic [31:0] RV [8] = '{32'h0000_0080, 32'h0000_000A, 32'h0000_09C4, 32'h0000_000A,
		32'h0000_0000, 32'h0000_02EF, 32'h0000_0BB9, 32'h0000_0000};
	// ****************************************
	// Clock, timeout, pulse counter
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (encp === 1'b1) npulse++;
		if (cycles == 6000) begin
			failures++;
			complete_run();
		end
	end
	sbg_far_model far (.i_ref_clk(clk), .o_prof_start(ps), .o_prof_end(pe), .o_enc_count(ec));
	sbg_status #(.MS_CYC(4)) dut (.i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hro),
		.o_hreadyout(hro), .o_hresp(hresp), .o_hrdata(hrdata), .i_op_stop(ops), .i_alarm(alarm),
		.i_alarm_is_022(a22), .i_motor_speed(speed), .i_spd_cmd_raw(cmd), .i_spd_fb_filt(fb),
		.i_enc_fault(enc_fault), .i_enc_count(ec), .i_enc_dir(enc_dir), .i_pulse_in(pin),
		.i_pulse_dir(pdir), .i_num_sel(nsel), .i_prof_start(ps), .i_prof_end(pe), .i_pos_err(pos_err),
		.o_brake_release(brk), .o_drive_en(den), .o_zero_speed(zs), .o_speed_reached(speed_reached_range),
		.o_cmd_done(done), .o_pos_reached(posr), .o_motion_complete(mc), .o_do_mc(domc),
		.o_alarm_018(a18), .o_alarm_380(a380), .o_enc_pulse(encp), .o_enc_dir(encd),
		.o_pos_delta(pdelta), .o_pos_valid(pv));
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] ix, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0_0000, ix, 2'b00};
		hwrite <= w;
		@(posedge clk);
		while (hro !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hro !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic wr(input logic [9:0] ix, input logic [31:0] d);
		bus(1'b1, ix, d);
	endtask
	task automatic rg(input logic [9:0] ix, input logic [31:0] e);
		bus(1'b0, ix, 32'h0000_0000);
		cmp("register", e, rd);
		cmp("response", 32'h0000_0000, {31'h0, hresp});
	endtask
	task automatic motion(input logic [31:0] sel, input logic ec1, input logic ea);
		wr(`SBG_IX_MCSEL, sel);
		wr(`SBG_IX_STAT, 32'h0000_0003);
		pos_err <= 32'h0000_0000;
		far.strobe(0);
		tick(2);
		cmp("complete", 32'h0, {31'h0, mc});
		cmp("done", 32'h0, {31'h0, done});
		far.strobe(1);
		tick(5);
		cmp("done", 32'h1, {31'h0, done});
		cmp("complete", 32'h1, {31'h0, mc});
		cmp("do_mc", 32'h1, {31'h0, domc});
		pos_err <= 32'hFFFF_FFFF;
		tick(3);
		cmp("reached", 32'h0, {31'h0, posr});
		cmp("complete", {31'h0, ec1}, {31'h0, mc});
		cmp("al380", {31'h0, ea}, {31'h0, a380});
	endtask
	// One input pulse, then wait for the scaled step
	task automatic gear(input logic [31:0] e);
		pin <= 1'b1;
		tick(3);
		pin <= 1'b0;
		@(posedge clk);
		while (pv !== 1'b1) @(posedge clk);
		cmp("pos_delta", e, pdelta);
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		{hsel, hwrite, alarm, enc_fault, enc_dir} = 5'b0;
		{ops, a22, pin, pdir, nsel} = '0;
		{htrans, haddr, hwdata, pos_err} = '0;
		speed = 17'sd500;
		cmd = 16'sd100;
		fb = 16'sd0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		for (int i = 0; i < 8; i++) rg(RIX[i], RV[i]);
		wr(`SBG_IX_NUM0, 32'h0000_0040);
		rg(`SBG_IX_NUM0, 32'h0000_0080);
		wr(`SBG_IX_CTRL, 32'h0000_0001);
		tick(3);
		cmp("release", 32'h1, {31'h0, brk});
		wr(`SBG_IX_NUM0, 32'h0000_0040);
		rg(`SBG_IX_NUM0, 32'h0000_0040);
		wr(`SBG_IX_DEN, 32'h0000_0007);
		rg(`SBG_IX_DEN, 32'h0000_000A);
		wr(`SBG_IX_OFFDLY, 32'h0000_0003);
		wr(`SBG_IX_CTRL, 32'h0000_0000);
		tick(3);
		cmp("release", 32'h1, {31'h0, brk});
		cmp("drive", 32'h0, {31'h0, den});
		tick(14);
		cmp("release", 32'h0, {31'h0, brk});
		wr(`SBG_IX_CTRL, 32'h0000_0001);
		wr(`SBG_IX_OFFDLY, 32'h0000_03E8);
		wr(`SBG_IX_CTRL, 32'h0000_0000);
		tick(3);
		cmp("release", 32'h1, {31'h0, brk});
		speed <= 17'sd50;
		tick(3);
		cmp("release", 32'h0, {31'h0, brk});
		speed <= 17'sd500;
		wr(`SBG_IX_OFFDLY, 32'hFFFF_FFFE);
		wr(`SBG_IX_CTRL, 32'h0000_0001);
		tick(3);
		alarm <= 1'b1;
		tick(3);
		cmp("release", 32'h0, {31'h0, brk});
		cmp("drive", 32'h0, {31'h0, den});
		alarm <= 1'b0;
		ops <= 1'b1;
		tick(5);
		cmp("release", 32'h0, {31'h0, brk});
		ops <= 1'b0;
		tick(3);
		wr(`SBG_IX_CTRL, 32'h0000_0002);
		tick(12);
		wr(`SBG_IX_NUM0, 32'h2000_0000);
		rg(`SBG_IX_NUM0, 32'h0000_0040);
		wr(`SBG_IX_NUM0, 32'h1FFF_FFFF);
		rg(`SBG_IX_NUM0, 32'h1FFF_FFFF);
		wr(`SBG_IX_DEN, 32'h0000_0000);
		rg(`SBG_IX_DEN, 32'h0000_000A);
		wr(`SBG_IX_DEN, 32'h7FFF_FFFF);
		rg(`SBG_IX_DEN, 32'h7FFF_FFFF);
		wr(`SBG_IX_NUM0, 32'h0000_000F);
		wr(`SBG_IX_DEN, 32'h0000_000A);
		gear(32'h0000_0001);
		gear(32'h0000_0002);
		fb <= 16'sd90;
		tick(3);
		cmp("speed_ok", 32'h1, {31'h0, speed_reached_range});
		fb <= 16'sd89;
		tick(3);
		cmp("speed_ok", 32'h0, {31'h0, speed_reached_range});
		wr(`SBG_IX_SPR, 32'h0000_012D);
		rg(`SBG_IX_SPR, 32'h0000_000A);
		wr(`SBG_IX_SPR, 32'h0000_0000);
		fb <= 16'sd100;
		tick(3);
		cmp("speed_ok", 32'h0, {31'h0, speed_reached_range});
		speed <= 17'sd100;
		tick(3);
		cmp("zero", 32'h1, {31'h0, zs});
		speed <= 17'sd101;
		tick(3);
		cmp("zero", 32'h0, {31'h0, zs});
		wr(`SBG_IX_PPR, 32'h0000_0013);
		rg(`SBG_IX_PPR, 32'h0000_09C4);
		wr(`SBG_IX_PPR, 32'h0004_E200);
		rg(`SBG_IX_PPR, 32'h0004_E200);
		npulse = 0;
		enc_dir <= 1'b1;
		repeat (4) far.strobe(2);
		tick(3);
		cmp("enc_pulses", 32'h1, npulse);
		cmp("enc_dir", 32'h1, {31'h0, encd});
		enc_fault <= 1'b1;
		tick(3);
		cmp("al018", 32'h1, {31'h0, a18});
		enc_fault <= 1'b0;
		wr(`SBG_IX_STAT, 32'h0000_0001);
		tick(2);
		cmp("al018", 32'h0, {31'h0, a18});
		motion(32'h0000_0011, 1'b1, 1'b1);
		motion(32'h0000_0000, 1'b0, 1'b0);
		complete_run();
	end
endmodule // servo_brake_gear_status_logic_test
`default_nettype wire
